/* File: swc_map.svh */
// Purpose: offsets, fields, resets and counts of the sleep/wake controller
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: one rule a line below
// Function
// - Sleep is entered only when the CPU executes the power-down instruction.
// - Entering sleep clears the watchdog; it runs on when enabled in sleep.
// - Completed entry clears the powerdown flag and sets the timeout flag.
// - In sleep the CPU clock stops and I/O pins hold their drive.
// - Low-frequency and timer1 oscillators keep running in sleep.
// - Converter on its RC clock and capacitive oscillator keep running.
// - Sleep leaves every reset source except the watchdog untouched.
// - Wake on master clear, brown-out, power-on, watchdog or interrupts.
// - Reset sources reset the device; watchdog or interrupt resume code.
// - The instruction after power-down is prefetched during it.
// - Interrupt wake needs the source enable, not the global enable.
// - Global enable off: run in line; on: next instruction then 0004h; here 0004h comes with the resume pulse.
// - Every wake clears the watchdog.
// - Pending enabled interrupt turns power-down into a no-operation.
// - Interrupt during or after entry: complete entry, wake at once.
// - Crystal modes add 1024 oscillator periods of start-up on wake.
// - Flags set on events regardless of any enable.
// - Request register four: rx bit 5, tx bit 4, collision 1, event 0.
// - Stay in reset until the regulator capacitor is charged.
// - Watchdog time-out in sleep wakes and updates the status flags.
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH
`define SWC_ADDR_REQ4      12'h000
`define SWC_ADDR_ENA4      12'h004
`define SWC_ADDR_INTCTL    12'h008
`define SWC_ADDR_STATUS    12'h00c
`define SWC_ADDR_WDTCTL    12'h010
`define SWC_REQ4_MASK      8'h33
`define SWC_INTCTL_MASK    8'hd2
`define SWC_WDTCTL_MASK    8'h3f
`define SWC_WDTCTL_RESET   8'h16
`define SWC_BIT_GLOBAL_EN  7
`define SWC_BIT_EXT_EN     4
`define SWC_BIT_EXT_FLAG   1
`define SWC_BIT_TIMEOUT    4
`define SWC_BIT_POWERDOWN  3
`define SWC_BIT_SW_WDT_EN  0
`define SWC_OST_TOSC       1024
`define SWC_ISR_VECTOR     15'h0004
`define SWC_NSYNC          5
`endif

/* File: swc_pkg.sv */
// Purpose: types of the sleep/wake controller
// Assumes: constants live in swc_map.svh
// Notes: one state machine, one event struct
package swc_pkg;
  typedef enum logic [2:0] {
    SWC_RESET,
    SWC_AWAKE,
    SWC_SLEEP,
    SWC_OST,
    SWC_RESUME
  } swc_state_e;

  typedef struct packed {
    logic [3:0] serial_sync;
    logic       periph_wake;
    logic       wdt_timeout;
    logic       clrwdt;
  } swc_evt_s;
endpackage : swc_pkg

/* File: swc_ctrl.sv */
// Purpose: power-down entry, wake decision and reset hold for the core
// Assumes: sys_clk 250 MHz is also the oscillator whose periods are counted
// Notes: APB slave, zero wait states, read data registered in setup phase
`include "swc_map.svh"

module swc_ctrl
  import swc_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu core
  input  wire logic        sleep_exec,
  output logic             prefetch_req,
  output logic             cpu_clk_en,
  output logic             resume_pulse,
  output logic             vector_req,
  output logic      [14:0] vector_addr,
  output logic             device_reset,
  // events from peripherals and watchdog, same clock
  input  swc_evt_s         evt,
  // asynchronous pins
  input  wire logic        master_clear_pin_n,
  input  wire logic        brownout_reset,
  input  wire logic        por_active,
  input  wire logic        ext_int_pin,
  input  wire logic        cap_charged,
  // configuration
  input  wire logic        master_clear_en,
  input  wire logic        brownout_en,
  input  wire logic        xtal_mode,
  input  wire logic [1:0]  wdt_mode,
  // clock and pin control
  output logic             wdt_clear,
  output logic             wdt_run,
  output logic             io_hold,
  output logic             low_freq_internal_osc_en,
  output logic             timer1_osc_en,
  output logic             converter_rc_clock_en,
  output logic             cap_sense_osc_en
);

  swc_state_e  state;
  swc_state_e  next_state;
  logic [7:0]  peripheral_request_four;
  logic [7:0]  peripheral_enable_four;
  logic [7:0]  interrupt_control;
  logic [7:0]  watchdog_control;
  logic        timeout_flag;
  logic        powerdown_flag;
  logic [10:0] ost_cnt;
  logic [`SWC_NSYNC-1:0] pin_raw;
  logic [`SWC_NSYNC-1:0] pin_s1;
  logic [`SWC_NSYNC-1:0] pin_s2;
  logic [`SWC_NSYNC-1:0] pin_s3;
  logic [`SWC_NSYNC-1:0] pin_lvl;
  logic        ext_int_q;
  logic        rst_src;
  logic        wake_irq;
  logic        enter;
  logic        wr;
  logic        rd;
  logic        hit;

  localparam logic [10:0] OST_LAST = 11'(`SWC_OST_TOSC - 1);

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] ref_a);
    addr_is = (a == ref_a);
  endfunction : addr_is

  // asynchronous pins: three stages, a change counts once two agree
  assign pin_raw = {cap_charged, por_active, ~master_clear_pin_n,
                    brownout_reset, ext_int_pin};

  genvar g;
  generate
    for (g = 0; g < `SWC_NSYNC; g++)
    begin : g_sync
      always_ff @(posedge sys_clk)
      begin
        if (!resetn)
        begin
          pin_s1[g]  <= 1'b0;
          pin_s2[g]  <= 1'b0;
          pin_s3[g]  <= 1'b0;
          pin_lvl[g] <= 1'b0;
        end
        else
        begin
          pin_s1[g] <= pin_raw[g];
          pin_s2[g] <= pin_s1[g];
          pin_s3[g] <= pin_s2[g];
          if (pin_s2[g] == pin_s3[g])
            pin_lvl[g] <= pin_s3[g];
        end
      end
    end
  endgenerate

  // sleep does not mask these; power-on and capacitor always reset, master clear and brown-out when enabled
  assign rst_src = pin_lvl[3] | (master_clear_en & pin_lvl[2])
                 | (brownout_en & pin_lvl[1]) | ~pin_lvl[4];

  // wake needs only the source enable, never the global one
  assign wake_irq = |(peripheral_request_four & peripheral_enable_four)
                  | (interrupt_control[`SWC_BIT_EXT_EN]
                     & interrupt_control[`SWC_BIT_EXT_FLAG])
                  | evt.periph_wake;

  // a pending enabled interrupt turns the instruction into a no-op
  assign enter = (state == SWC_AWAKE) & sleep_exec & ~wake_irq;

  assign wr  = psel & penable & pwrite;
  assign rd  = psel & ~penable & ~pwrite;
  assign hit = addr_is(paddr, `SWC_ADDR_REQ4)
             | addr_is(paddr, `SWC_ADDR_ENA4)
             | addr_is(paddr, `SWC_ADDR_INTCTL)
             | addr_is(paddr, `SWC_ADDR_STATUS)
             | addr_is(paddr, `SWC_ADDR_WDTCTL);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always_comb
  begin
    next_state = state;
    unique case (state)
      SWC_RESET:
        if (!rst_src)
          next_state = SWC_AWAKE;
      SWC_AWAKE:
        if (rst_src || (evt.wdt_timeout && wdt_run))
          next_state = SWC_RESET;
        else if (enter)
          next_state = SWC_SLEEP;
      SWC_SLEEP:
        if (rst_src)
          next_state = SWC_RESET;
        else if (wake_irq || (evt.wdt_timeout && wdt_run))
          next_state = xtal_mode ? SWC_OST : SWC_RESUME;
      SWC_OST:
        if (rst_src)
          next_state = SWC_RESET;
        else if (ost_cnt == OST_LAST)
          next_state = SWC_RESUME;
      SWC_RESUME:
        next_state = rst_src ? SWC_RESET : SWC_AWAKE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      state <= SWC_RESET;
    else
      state <= next_state;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || state != SWC_OST)
      ost_cnt <= 11'h000;
    else
      ost_cnt <= ost_cnt + 11'h001;
  end

  // flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || rst_src)
      peripheral_request_four <= 8'h00;
    else
    begin
      if (wr && addr_is(paddr, `SWC_ADDR_REQ4))
        peripheral_request_four <= pwdata[7:0] & `SWC_REQ4_MASK;
      peripheral_request_four[5:4] <= (wr && addr_is(paddr, `SWC_ADDR_REQ4)
        ? pwdata[5:4] : peripheral_request_four[5:4])
        | evt.serial_sync[3:2];
      peripheral_request_four[1:0] <= (wr && addr_is(paddr, `SWC_ADDR_REQ4)
        ? pwdata[1:0] : peripheral_request_four[1:0])
        | evt.serial_sync[1:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || rst_src)
      peripheral_enable_four <= 8'h00;
    else if (wr && addr_is(paddr, `SWC_ADDR_ENA4))
      peripheral_enable_four <= pwdata[7:0] & `SWC_REQ4_MASK;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || rst_src)
      ext_int_q <= 1'b0;
    else
      ext_int_q <= pin_lvl[0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || rst_src)
      interrupt_control <= 8'h00;
    else
    begin
      if (wr && addr_is(paddr, `SWC_ADDR_INTCTL))
        interrupt_control <= pwdata[7:0] & `SWC_INTCTL_MASK;
      if (pin_lvl[0] && !ext_int_q)
        interrupt_control[`SWC_BIT_EXT_FLAG] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || rst_src)
      watchdog_control <= `SWC_WDTCTL_RESET;
    else if (wr && addr_is(paddr, `SWC_ADDR_WDTCTL))
      watchdog_control <= pwdata[7:0] & `SWC_WDTCTL_MASK;
  end

  // both flags read 1 after a power-on style reset
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || (rst_src && state != SWC_RESET))
    begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end
    else if (state == SWC_AWAKE && evt.wdt_timeout && wdt_run)
      timeout_flag <= 1'b0;
    else if (state == SWC_SLEEP && evt.wdt_timeout && wdt_run)
      timeout_flag <= 1'b0;
    else if (enter)
    begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b0;
    end
    else if (state == SWC_AWAKE && evt.clrwdt)
    begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      prdata <= 32'h0000_0000;
    else if (rd)
    begin
      prdata <= 32'h0000_0000;
      if (addr_is(paddr, `SWC_ADDR_REQ4))
        prdata[7:0] <= peripheral_request_four;
      if (addr_is(paddr, `SWC_ADDR_ENA4))
        prdata[7:0] <= peripheral_enable_four;
      if (addr_is(paddr, `SWC_ADDR_INTCTL))
        prdata[7:0] <= interrupt_control;
      if (addr_is(paddr, `SWC_ADDR_STATUS))
      begin
        prdata[`SWC_BIT_TIMEOUT]   <= timeout_flag;
        prdata[`SWC_BIT_POWERDOWN] <= powerdown_flag;
      end
      if (addr_is(paddr, `SWC_ADDR_WDTCTL))
        prdata[7:0] <= watchdog_control;
    end
  end

  // watchdog enable per mode; mode 10 stops it in sleep
  always_comb
  begin
    unique case (wdt_mode)
      2'b11: wdt_run = 1'b1;
      2'b10: wdt_run = (state == SWC_AWAKE) || (state == SWC_RESUME);
      2'b01: wdt_run = watchdog_control[`SWC_BIT_SW_WDT_EN];
      2'b00: wdt_run = 1'b0;
    endcase
  end

  // cleared on entry, on every wake and while start-up runs
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      wdt_clear <= 1'b1;
    else
      wdt_clear <= enter
                 || (state == SWC_SLEEP && next_state != SWC_SLEEP)
                 || next_state == SWC_OST || next_state == SWC_RESET
                 || (state == SWC_AWAKE && evt.clrwdt) || !wdt_run;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      cpu_clk_en   <= 1'b0;
      io_hold      <= 1'b0;
      device_reset <= 1'b1;
    end
    else
    begin
      cpu_clk_en   <= next_state == SWC_AWAKE
                   || next_state == SWC_RESUME;
      io_hold      <= next_state == SWC_SLEEP
                   || next_state == SWC_OST;
      device_reset <= next_state == SWC_RESET;
    end
  end

  // resume: global enable decides the vector, raised in the same cycle as the resume pulse
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      resume_pulse <= 1'b0;
      vector_req   <= 1'b0;
      vector_addr  <= 15'h0000;
    end
    else
    begin
      resume_pulse <= next_state == SWC_RESUME;
      vector_req   <= next_state == SWC_RESUME && wake_irq
                   && interrupt_control[`SWC_BIT_GLOBAL_EN];
      vector_addr  <= `SWC_ISR_VECTOR;
    end
  end

  // prefetch happens whether or not the entry completes
  assign prefetch_req = (state == SWC_AWAKE) & sleep_exec;

  // slow oscillators and sleep-capable clocks never stop here
  assign low_freq_internal_osc_en = 1'b1;
  assign timer1_osc_en            = 1'b1;
  assign converter_rc_clock_en    = 1'b1;
  assign cap_sense_osc_en         = 1'b1;

endmodule : swc_ctrl

/* File: swc_props.sv */
// Purpose: port timing checks of the sleep/wake controller
// Assumes: one clock, synchronous active-low reset
// Notes: start-up window allows a few cycles of wake latency
module swc_props
  import swc_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // core side
  input wire logic        sleep_exec,
  input wire logic        prefetch_req,
  input wire logic        cpu_clk_en,
  input wire logic        resume_pulse,
  input wire logic        vector_req,
  input wire logic [14:0] vector_addr,
  input wire logic        device_reset,
  // pins and control
  input wire logic        cap_charged,
  input wire logic        xtal_mode,
  input wire logic [1:0]  wdt_mode,
  input wire logic        wdt_clear,
  input wire logic        wdt_run,
  input wire logic        io_hold,
  input wire logic        timer1_osc_en,
  input wire logic        low_freq_internal_osc_en,
  input wire logic        converter_rc_clock_en,
  input wire logic        cap_sense_osc_en
);
  logic [10:0] hold_cnt;

  // saturates so a stuck start-up cannot wrap back into the window
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !(io_hold && wdt_clear))
      hold_cnt <= 11'h000;
    else if (hold_cnt != 11'h7ff)
      hold_cnt <= hold_cnt + 11'h001;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_entry;
    $fell(cpu_clk_en) && !device_reset |-> $past(sleep_exec);
  endproperty
  a_entry: assert property (p_entry)
    else $error("core clock stopped without power-down");
  property p_enter;
    $fell(cpu_clk_en) && !device_reset |-> io_hold && wdt_clear;
  endproperty
  a_enter: assert property (p_enter)
    else $error("entry did not hold pins or clear watchdog");
  property p_hold;
    io_hold |-> !cpu_clk_en;
  endproperty
  a_hold: assert property (p_hold)
    else $error("core clock running while pins held");
  property p_prefetch;
    sleep_exec && cpu_clk_en && !device_reset && !resume_pulse
      |-> prefetch_req;
  endproperty
  a_prefetch: assert property (p_prefetch)
    else $error("no prefetch with power-down");
  property p_osc;
    io_hold |-> timer1_osc_en && low_freq_internal_osc_en
      && converter_rc_clock_en && cap_sense_osc_en;
  endproperty
  a_osc: assert property (p_osc)
    else $error("sleep-capable clock stopped in sleep");
  property p_vector;
    vector_req |-> resume_pulse && vector_addr == 15'h0004;
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector without resume or wrong address");
  property p_wdt_sleep;
    io_hold && !wdt_clear && wdt_mode[1] |-> wdt_run == wdt_mode[0];
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep)
    else $error("watchdog run wrong in sleep");
  // modes 00, 10 and 01 with its enable bit clear keep the watchdog clear all through sleep, so the
  // start-up hold can only be timed when it runs in sleep
  property p_ost;
    resume_pulse && xtal_mode && wdt_mode == 2'b11
      |-> hold_cnt >= 11'h3ff && hold_cnt <= 11'h404;
  endproperty
  a_ost: assert property (p_ost)
    else $error("crystal start-up length wrong");
  property p_fast;
    resume_pulse && !xtal_mode && wdt_mode == 2'b11
      |-> hold_cnt <= 11'h002;
  endproperty
  a_fast: assert property (p_fast)
    else $error("start-up delay outside crystal mode");
  property p_wake_clr;
    $rose(resume_pulse) |-> wdt_clear || $past(wdt_clear)
      || $past(wdt_clear, 2);
  endproperty
  a_wake_clr: assert property (p_wake_clr)
    else $error("wake without watchdog clear");
  property p_cap;
    (!cap_charged) [*8] |-> device_reset;
  endproperty
  a_cap: assert property (p_cap)
    else $error("reset released before capacitor charged");

  c_sleep: cover property ($fell(cpu_clk_en) && !device_reset);
  c_vec: cover property (vector_req);
  c_ost: cover property (resume_pulse && xtal_mode);
endmodule : swc_props

bind swc_ctrl swc_props swc_props_inst (
  .sys_clk, .resetn, .sleep_exec, .prefetch_req, .cpu_clk_en,
  .resume_pulse, .vector_req, .vector_addr, .device_reset,
  .cap_charged, .xtal_mode, .wdt_mode, .wdt_clear, .wdt_run,
  .io_hold, .timer1_osc_en, .low_freq_internal_osc_en,
  .converter_rc_clock_en, .cap_sense_osc_en
);

/* File: swc_core_model.sv */
// Purpose: core model issuing power-down and following resume
// Assumes: the core executes only while its clock is enabled
// Notes: pc is a coarse instruction counter, not a real fetch
module swc_core_model
(
  // clock
  input  wire logic        sys_clk,
  // bench command
  input  wire logic        go_sleep,
  // controller side
  input  wire logic        cpu_clk_en,
  input  wire logic        prefetch_req,
  input  wire logic        resume_pulse,
  input  wire logic        vector_req,
  input  wire logic [14:0] vector_addr,
  input  wire logic        device_reset,
  output logic             sleep_exec,
  output logic      [14:0] pc
);
  // a stopped core cannot execute, so the request is dropped while its clock is off
  assign sleep_exec = go_sleep && cpu_clk_en;

  always_ff @(posedge sys_clk)
  begin
    if (device_reset)
      pc <= 15'h0000;
    else if (vector_req)
      pc <= vector_addr;
    else if (prefetch_req || resume_pulse)
      pc <= pc + 15'h0001;
  end
endmodule : swc_core_model

/* File: test_sleep_wake_controller.sv */
// Purpose: directed test of the sleep/wake controller
// Assumes: zero-wait register bus, outputs sampled at falling edges
// Notes: crystal start-up runs its full length
`include "swc_map.svh"

module test_sleep_wake_controller
  import swc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk = 1'b0, resetn = 1'b0, go_sleep = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, sleep_exec, prefetch_req, cpu_clk_en;
  logic        resume_pulse, vector_req, device_reset;
  logic [14:0] vector_addr, pc;
  logic        clear_n = 1'b1, cap_charged = 1'b0, ext_int = 1'b0;
  logic        xtal_mode = 1'b0, por = 1'b0, bo = 1'b0;
  logic [1:0]  wdt_mode = 2'b10;
  logic [3:0]  mon;
  swc_evt_s    evt = '0;
  int          fails = 0, check_count = 0, n;

  assign mon = {device_reset, resume_pulse, cpu_clk_en, vector_req};
  always #2 sys_clk = ~sys_clk;

  swc_ctrl swc_ctrl_inst (
    .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sleep_exec, .prefetch_req,
    .cpu_clk_en, .resume_pulse, .vector_req, .vector_addr,
    .device_reset, .evt, .master_clear_pin_n(clear_n),
    .brownout_reset(bo), .por_active(por), .ext_int_pin(ext_int),
    .cap_charged, .master_clear_en(1'b1), .brownout_en(1'b1),
    .xtal_mode,
    .wdt_mode, .wdt_clear(), .wdt_run(), .io_hold(),
    .low_freq_internal_osc_en(), .timer1_osc_en(),
    .converter_rc_clock_en(), .cap_sense_osc_en()
  );
  swc_core_model swc_core_model_inst (
    .sys_clk, .go_sleep, .cpu_clk_en, .prefetch_req, .resume_pulse,
    .vector_req, .vector_addr, .device_reset, .sleep_exec, .pc
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  // mon index: 0 vector, 1 core clock, 2 resume, 3 device reset
  task automatic wait_v(input int i, input logic v, output int c);
    c = 0;
    do
    begin
      @(negedge sys_clk);
      c++;
      if (c > 2000)
      begin
        chk("wait limit", 32'h0, 32'h1);
        test_done();
      end
    end
    while (mon[i] !== v);
  endtask : wait_v

  task automatic see(input int i, input logic v, input string w);
    @(negedge sys_clk);
    chk(w, {31'h0, v}, {31'h0, mon[i]});
  endtask : see

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int k;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
      if (k > 20)
      begin
        chk("ready limit", 32'h0, 32'h1);
        test_done();
      end
    end
    while (pready !== 1'b1);
    q = prdata;
    chk("slverr", {31'h0, a > 12'h010}, {31'h0, pslverr});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [7:0] e,
                    input string w);
    logic [31:0] q;
    apb(1'b0, a, 8'h00, q);
    chk(w, {24'h0, e}, q);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic pulse(input swc_evt_s e);
    @(posedge sys_clk);
    evt <= e;
    @(posedge sys_clk);
    evt <= '0;
  endtask : pulse

  task automatic sleep();
    @(posedge sys_clk);
    go_sleep <= 1'b1;
    @(posedge sys_clk);
    go_sleep <= 1'b0;
  endtask : sleep

  initial
  begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (20) @(posedge sys_clk);
    see(3, 1'b1, "reset held");
    @(posedge sys_clk);
    cap_charged <= 1'b1;
    wait_v(3, 1'b0, n);
    rd(`SWC_ADDR_REQ4, 8'h00, "request4");
    rd(`SWC_ADDR_WDTCTL, 8'h16, "wdtctl");
    rd(`SWC_ADDR_STATUS, 8'h18, "status");
    rd(12'h020, 8'h00, "unmapped");
    pulse(7'h78);
    rd(`SWC_ADDR_REQ4, 8'h33, "flags");
    wr(`SWC_ADDR_REQ4, 8'h00);
    wr(`SWC_ADDR_REQ4, 8'hff);
    rd(`SWC_ADDR_REQ4, 8'h33, "flags set");
    wr(`SWC_ADDR_REQ4, 8'h00);
    wr(`SWC_ADDR_ENA4, 8'h01);
    pulse(7'h08);
    sleep();
    see(1, 1'b1, "pending no-op");
    rd(`SWC_ADDR_STATUS, 8'h18, "no-op status");
    wr(`SWC_ADDR_REQ4, 8'h00);
    for (int g = 0; g < 2; g++)
    begin
      wr(`SWC_ADDR_INTCTL, {g[0], 7'h00});
      wr(`SWC_ADDR_ENA4, 8'h20);
      sleep();
      see(1, 1'b0, "asleep");
      rd(`SWC_ADDR_STATUS, 8'h10, "sleep status");
      pulse(7'h40);
      wait_v(2, 1'b1, n);
      chk("vector", {31'h0, g[0]}, {31'h0, mon[0]});
      wr(`SWC_ADDR_REQ4, 8'h00);
    end
    chk("pc", 32'h4, {17'h0, pc});
    wr(`SWC_ADDR_ENA4, 8'h00);
    sleep();
    pulse(7'h02);
    see(1, 1'b0, "watchdog off in sleep");
    @(posedge sys_clk);
    wdt_mode <= 2'b11;
    pulse(7'h02);
    wait_v(2, 1'b1, n);
    rd(`SWC_ADDR_STATUS, 8'h00, "wdt wake");
    pulse(7'h01);
    rd(`SWC_ADDR_STATUS, 8'h18, "clrwdt");
    xtal_mode <= 1'b1;
    wr(`SWC_ADDR_INTCTL, 8'h10);
    sleep();
    ext_int <= 1'b1;
    wait_v(2, 1'b1, n);
    chk("ost", 32'h1, {31'h0, n >= 1024 && n <= 1034});
    @(posedge sys_clk);
    ext_int   <= 1'b0;
    xtal_mode <= 1'b0;
    wr(`SWC_ADDR_INTCTL, 8'h00);
    // pin clear, power-on and brown-out each reset a sleeping device
    for (int s = 0; s < 3; s++)
    begin
      sleep();
      clear_n <= s != 0;
      por     <= s == 1;
      bo      <= s == 2;
      wait_v(3, 1'b1, n);
      @(posedge sys_clk);
      clear_n <= 1'b1;
      por     <= 1'b0;
      bo      <= 1'b0;
      wait_v(3, 1'b0, n);
      rd(`SWC_ADDR_STATUS, 8'h18, "reset status");
    end
    test_done();
  end
endmodule : test_sleep_wake_controller
